// file: hdl/stk_bus_slave.sv
// stk_bus_slave: Avalon-MM handshake, one wait cycle per access, decodes strobes
// assumes: master holds its request until waitrequest is seen low
`timescale 1ns/1ps
`default_nettype none
module stk_bus_slave (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire stk_pkg::stk_req_s req,
    output logic                   waitrequest,
    output logic                   acc_read,
    output logic                   acc_write
);

    stk_pkg::stk_bus_e state;

    // ==========================================================
    // accept every access after one wait cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            state <= stk_pkg::STK_IDLE;
        else
            unique case (state)
                stk_pkg::STK_IDLE:
                    if (req.read || req.write)
                        state <= stk_pkg::STK_DONE;
                stk_pkg::STK_DONE:
                    state <= stk_pkg::STK_IDLE;
            endcase
    end

    assign waitrequest = !(state == stk_pkg::STK_DONE);
    assign acc_read    = (state == stk_pkg::STK_DONE) && req.read;
    assign acc_write   = (state == stk_pkg::STK_DONE) && req.write;

endmodule : stk_bus_slave
`default_nettype wire

// file: hdl/stk_pkg.sv
// stk_pkg: register map, field positions, reset values and bus types of the tick timer
// assumes: a 32-bit Avalon-MM slave with word addresses given as byte offsets
package stk_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h10;
    localparam logic [7:0] OFS_RELOAD      = 8'h14;
    localparam logic [7:0] OFS_CURRENT     = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h20;

    // ==========================================================
    // field positions
    localparam int CNT_W          = 24;
    localparam int BIT_ENABLE     = 0;
    localparam int BIT_EXC_ENABLE = 1;
    localparam int BIT_CLK_SELECT = 2;
    localparam int BIT_WRAP_FLAG  = 16;
    localparam int BIT_IRQ_WRAP   = 0;

    // ==========================================================
    // reset values
    localparam logic [31:0] RST_CTRL_STATUS = 32'h0000_0004;
    localparam logic [23:0] RST_RELOAD      = 24'h00_0000;
    localparam logic [23:0] RST_CURRENT     = 24'h00_0000;
    localparam logic        RST_IRQ_MASK    = 1'b0;

    // ==========================================================
    // bus request carrier
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } stk_req_s;

    typedef enum logic [0:0] {
        STK_IDLE,
        STK_DONE
    } stk_bus_e;

endpackage : stk_pkg

// file: hdl/stk_system_tick_timer.sv
// stk_system_tick_timer: 24-bit down-counting tick timer with Avalon-MM registers
// assumes: single clock, synchronous reset, alt_tick from external clock selection
// What this block does
// R1: 24-bit down counter wrapping on zero, cleared by current value writes.
// R2: when enabled counts down to zero then loads reload value next count.
// R3: wrap flag bit 16 sets when count goes from 1 to 0.
// R4: wrap flag clears on status read or current value write.
// R5: zero reload value keeps counter at zero, so ticking stops.
// R6: control bit 2 picks core clock (1) or alternate tick (0).
// R7: with bit 1 set, reaching zero pends exception; software clear never does.
// R8: control bit 0 enables repeated counting; cleared stops the counter.
// R9: reload bits 23:0 hold value copied into counter at zero.
// R10: any write to current value clears counter to zero.
// R11: current value reads counter now; bits 31:24 read zero.
// R12: software should clear current value before enabling the counter.
// R13: reserved bits read zero and ignore writes.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module stk_system_tick_timer (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        alt_tick,
    output logic             tick_exception,
    output logic             irq
);

    stk_pkg::stk_req_s req;
    logic              acc_read;
    logic              acc_write;
    logic              count_en;
    logic              enable;
    logic              wrap_exception_enable;
    logic              tick_clock_select;
    logic              wrap_flag;
    logic [23:0]       reload;
    logic [23:0]       current;
    logic              irq_status;
    logic              irq_mask;
    logic              wr_ctrl;
    logic              wr_reload;
    logic              wr_current;
    logic              wr_irq_status;
    logic              wr_irq_mask;
    logic              rd_ctrl;
    logic              step;
    logic              hit_zero;
    logic [31:0]       be_mask;
    logic [31:0]       wdata;
    logic [31:0]       next_readdata;
    logic              sel_ctrl;
    logic              sel_reload;
    logic              sel_current;
    logic              sel_irq_status;
    logic              sel_irq_mask;
    logic              rd_capture;
    logic              flag_read;
    logic              at_zero;
    logic              at_one;
    logic              wrap_event;
    logic              next_enable;
    logic              next_wrap_exception_enable;
    logic              next_tick_clock_select;
    logic [23:0]       next_reload;
    logic [23:0]       next_current;
    logic              next_wrap_flag;
    logic              next_tick_exception;
    logic              next_irq_status;
    logic              next_irq_mask;
    logic [31:0]       ctrl_word;
    logic [31:0]       reload_word;
    logic [31:0]       current_word;
    logic [31:0]       irq_status_word;
    logic [31:0]       irq_mask_word;

    // ==========================================================
    // bus front end
    assign req.address    = avs_address;
    assign req.read       = avs_read;
    assign req.write      = avs_write;
    assign req.writedata  = avs_writedata;
    assign req.byteenable = avs_byteenable;

    stk_bus_slave u_bus (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .req         (req),
        .waitrequest (avs_waitrequest),
        .acc_read    (acc_read),
        .acc_write   (acc_write)
    );

    stk_tick_enable u_tick (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .tick_clock_select (tick_clock_select),
        .alt_tick          (alt_tick),
        .count_en          (count_en)
    );

    // ==========================================================
    // byte lane merge
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_be
            assign be_mask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
        end
    endgenerate

    assign wdata = avs_writedata & be_mask;

    // ==========================================================
    // address decode, one select per register
    always_comb
    begin
        sel_ctrl       = 1'b0;
        sel_reload     = 1'b0;
        sel_current    = 1'b0;
        sel_irq_status = 1'b0;
        sel_irq_mask   = 1'b0;
        unique case (avs_address)
            stk_pkg::OFS_CTRL_STATUS: sel_ctrl       = 1'b1;
            stk_pkg::OFS_RELOAD:      sel_reload     = 1'b1;
            stk_pkg::OFS_CURRENT:     sel_current    = 1'b1;
            stk_pkg::OFS_IRQ_STATUS:  sel_irq_status = 1'b1;
            stk_pkg::OFS_IRQ_MASK:    sel_irq_mask   = 1'b1;
            default:                  sel_ctrl       = 1'b0; // R13
        endcase
    end

    assign wr_ctrl       = acc_write && sel_ctrl;
    assign wr_reload     = acc_write && sel_reload;
    assign wr_current    = acc_write && sel_current;
    assign wr_irq_status = acc_write && sel_irq_status;
    assign wr_irq_mask   = acc_write && sel_irq_mask;
    assign rd_ctrl       = acc_read && sel_ctrl;
    assign rd_capture    = avs_read && avs_waitrequest;
    assign flag_read     = rd_ctrl && avs_readdata[stk_pkg::BIT_WRAP_FLAG];

    // ==========================================================
    // control bits, lane 0 only
    always_comb
    begin
        next_enable                = enable;
        next_wrap_exception_enable = wrap_exception_enable;
        next_tick_clock_select     = tick_clock_select;
        if (wr_ctrl && avs_byteenable[0])
        begin
            next_enable                = avs_writedata[stk_pkg::BIT_ENABLE]; // R8
            next_wrap_exception_enable = avs_writedata[stk_pkg::BIT_EXC_ENABLE]; // R7
            next_tick_clock_select     = avs_writedata[stk_pkg::BIT_CLK_SELECT]; // R6
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            enable                <= stk_pkg::RST_CTRL_STATUS[stk_pkg::BIT_ENABLE];
            wrap_exception_enable <= stk_pkg::RST_CTRL_STATUS[stk_pkg::BIT_EXC_ENABLE];
            tick_clock_select     <= stk_pkg::RST_CTRL_STATUS[stk_pkg::BIT_CLK_SELECT];
        end
        else
        begin
            enable                <= next_enable;
            wrap_exception_enable <= next_wrap_exception_enable;
            tick_clock_select     <= next_tick_clock_select;
        end
    end

    // ==========================================================
    // reload register, byte lanes merged
    always_comb
    begin
        next_reload = reload;
        if (wr_reload)
            next_reload = (reload & ~be_mask[23:0]) | wdata[23:0]; // R9
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            reload <= stk_pkg::RST_RELOAD;
        else
            reload <= next_reload;
    end

    // ==========================================================
    // down counter
    assign at_zero  = (current == 24'h00_0000);
    assign at_one   = (current == 24'h00_0001);
    assign step     = enable && count_en; // R8
    assign hit_zero = step && at_one; // R3

    always_comb
    begin
        next_current = current;
        if (wr_current)
            next_current = 24'h00_0000; // R10
        else if (step && at_zero)
            next_current = reload; // R2 R5
        else if (step)
            next_current = current - 24'h00_0001; // R1
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            current <= stk_pkg::RST_CURRENT;
        else
            current <= next_current;
    end

    // ==========================================================
    // wrap flag: a wrap in the clearing cycle wins, and a read
    // only clears a flag that it has returned
    always_comb
    begin
        next_wrap_flag = wrap_flag;
        if (hit_zero)
            next_wrap_flag = 1'b1; // R3
        else if (flag_read || wr_current)
            next_wrap_flag = 1'b0; // R4
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            wrap_flag <= 1'b0;
        else
            wrap_flag <= next_wrap_flag;
    end

    // ==========================================================
    // wrap event: a current value write in the same cycle suppresses it
    assign wrap_event = hit_zero && !wr_current;

    // ==========================================================
    // exception pulse
    always_comb
    begin
        next_tick_exception = 1'b0;
        if (wrap_event)
            next_tick_exception = wrap_exception_enable; // R7
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            tick_exception <= 1'b0;
        else
            tick_exception <= next_tick_exception;
    end

    // ==========================================================
    // interrupt status, write one to clear
    always_comb
    begin
        next_irq_status = irq_status;
        if (wrap_event)
            next_irq_status = 1'b1;
        else if (wr_irq_status && wdata[stk_pkg::BIT_IRQ_WRAP])
            next_irq_status = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_status <= 1'b0;
        else
            irq_status <= next_irq_status;
    end

    // ==========================================================
    // interrupt mask and level output
    always_comb
    begin
        next_irq_mask = irq_mask;
        if (wr_irq_mask && avs_byteenable[0])
            next_irq_mask = avs_writedata[stk_pkg::BIT_IRQ_WRAP];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_mask <= stk_pkg::RST_IRQ_MASK;
        else
            irq_mask <= next_irq_mask;
    end

    assign irq = irq_status && irq_mask;

    // ==========================================================
    // read words, reserved bits zero
    always_comb
    begin
        ctrl_word                              = 32'h0000_0000;
        ctrl_word[stk_pkg::BIT_ENABLE]         = enable;
        ctrl_word[stk_pkg::BIT_EXC_ENABLE]     = wrap_exception_enable;
        ctrl_word[stk_pkg::BIT_CLK_SELECT]     = tick_clock_select;
        ctrl_word[stk_pkg::BIT_WRAP_FLAG]      = wrap_flag;
        irq_status_word                        = 32'h0000_0000;
        irq_status_word[stk_pkg::BIT_IRQ_WRAP] = irq_status;
        irq_mask_word                          = 32'h0000_0000;
        irq_mask_word[stk_pkg::BIT_IRQ_WRAP]   = irq_mask;
    end

    assign reload_word  = {8'h00, reload}; // R13
    assign current_word = {8'h00, current}; // R11

    // ==========================================================
    // read mux
    always_comb
    begin
        next_readdata = 32'h0000_0000;
        unique case (avs_address)
            stk_pkg::OFS_CTRL_STATUS: next_readdata = ctrl_word;
            stk_pkg::OFS_RELOAD:      next_readdata = reload_word;
            stk_pkg::OFS_CURRENT:     next_readdata = current_word; // R11
            stk_pkg::OFS_IRQ_STATUS:  next_readdata = irq_status_word;
            stk_pkg::OFS_IRQ_MASK:    next_readdata = irq_mask_word;
            default:                  next_readdata = 32'h0000_0000; // R13
        endcase
    end

    // ==========================================================
    // read data register, loaded in the wait cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            avs_readdata <= 32'h0000_0000;
        else if (rd_capture)
            avs_readdata <= next_readdata;
    end

endmodule : stk_system_tick_timer
`default_nettype wire

// file: hdl/stk_tick_enable.sv
// stk_tick_enable: count enable for the tick counter, held high on core clock, one pulse per alternate tick
// assumes: alt_tick is a one-cycle pulse synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module stk_tick_enable (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic tick_clock_select,
    input  wire logic alt_tick,
    output logic      count_en
);

    logic alt_q;

    // ==========================================================
    // register the alternate pulse to keep one edge per pulse
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            alt_q <= 1'b0;
        else
            alt_q <= alt_tick;
    end

    assign count_en = tick_clock_select ? 1'b1 : (alt_tick && !alt_q); // R6

endmodule : stk_tick_enable
`default_nettype wire

// file: tb/stk_alt_src.sv
// stk_alt_src: alternate count source, one pulse per period while run is high
// assumes: shares clk with the timer, drives its alt_tick input
`timescale 1ns/1ps
`default_nettype none
module stk_alt_src #(parameter int PERIOD = 4) (
    input  wire logic clk,
    input  wire logic run,
    output logic      alt_tick
);
    int cnt = 0;
    initial alt_tick = 1'b0;
    always @(posedge clk)
    begin
        cnt      <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        alt_tick <= run && (cnt == PERIOD - 1);
    end
endmodule : stk_alt_src
`default_nettype wire

// file: tb/stk_chk.sv
// stk_chk: port assertions for the tick timer
// assumes: bound to stk_system_tick_timer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module stk_chk (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        tick_exception,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // shadow of control and mask writes
    logic [2:0] ctl;
    logic       msk;
    logic       ack;
    assign ack = !avs_waitrequest && (avs_read || avs_write);
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctl <= 3'h4;
            msk <= 1'b0;
        end
        else if (ack && avs_write)
        begin
            if (avs_address == stk_pkg::OFS_CTRL_STATUS) ctl <= avs_writedata[2:0];
            if (avs_address == stk_pkg::OFS_IRQ_MASK) msk <= avs_writedata[0];
        end
    end
    // ==========================================================
    // assertions
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer one cycle after a request");
    wait_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without a request");
    exc_pulse_a: assert property (tick_exception |=> !tick_exception)
        else $error("exception longer than one cycle");
    exc_int_a: assert property (tick_exception |-> ctl[1] || $past(ctl[1]))
        else $error("exception with exception enable clear");
    exc_en_a: assert property (tick_exception |-> $past(ctl[0]))
        else $error("exception while counter disabled");
    clr_quiet_a: assert property (ack && avs_write && avs_address == stk_pkg::OFS_CURRENT
        |=> !tick_exception [*2])
        else $error("exception after a current value write");
    irq_mask_a: assert property (irq |-> msk)
        else $error("interrupt while masked");
    ctl_zero_a: assert property (ack && avs_read && avs_address == stk_pkg::OFS_CTRL_STATUS
        |-> avs_readdata[31:17] == 15'h0 && avs_readdata[15:3] == 13'h0)
        else $error("reserved control bits not zero");
    cnt_top_a: assert property (ack && avs_read && avs_address == stk_pkg::OFS_CURRENT
        |-> avs_readdata[31:24] == 8'h00)
        else $error("current value upper bits not zero");
    cov_exc_c: cover property (tick_exception);
    cov_irq_c: cover property ($rose(irq));
    cov_clr_c: cover property (ack && avs_write && avs_address == stk_pkg::OFS_CURRENT);
endmodule : stk_chk
bind stk_system_tick_timer stk_chk u_chk (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .tick_exception, .irq);
`default_nettype wire

// file: tb/test_stk_system_tick_timer.sv
// test_stk_system_tick_timer: register level tests of the tick timer
// assumes: stk_alt_src drives alt_tick, stk_chk is bound to the design
`timescale 1ns/1ps
`default_nettype none
module test_stk_system_tick_timer;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        alt_tick;
    logic        tick_exception;
    logic        irq;
    logic        alt_run = 1'b0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [3:0]  be_sel = 4'hF;
    logic [31:0] q;
    int          mismatches = 0;
    int          total_checks = 0;
    always #2 clk = ~clk;
    stk_system_tick_timer dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .alt_tick(alt_tick), .tick_exception(tick_exception), .irq(irq));
    stk_alt_src #(.PERIOD(4)) alt (.clk(clk), .run(alt_run), .alt_tick(alt_tick));
    // ==========================================================
    // tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= d;
        avs_byteenable <= be_sel;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rd
    task gap(input int exp);
        int c;
        for (c = 0; c < 300 && tick_exception !== 1'b1; c++) @(posedge clk);
        @(posedge clk);
        for (c = 1; c < 300 && tick_exception !== 1'b1; c++) @(posedge clk);
        check(c, exp);
    endtask : gap
    task quiet(input int n);
        int h;
        h = 0;
        repeat (n)
        begin
            @(posedge clk);
            if (tick_exception !== 1'b0) h++;
        end
        check(h, 0);
    endtask : quiet
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    // ==========================================================
    // tests
    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(stk_pkg::OFS_CTRL_STATUS, 32'h4);
        rd(8'h40, 32'h0);
        bus(1'b1, stk_pkg::OFS_RELOAD, 32'hFFFF_FFFF);
        rd(stk_pkg::OFS_RELOAD, 32'h00FF_FFFF);
        be_sel = 4'h1;
        bus(1'b1, stk_pkg::OFS_RELOAD, 32'h0000_0012);
        be_sel = 4'hF;
        rd(stk_pkg::OFS_RELOAD, 32'h00FF_FF12);
        bus(1'b1, stk_pkg::OFS_RELOAD, 32'h5);
        bus(1'b1, stk_pkg::OFS_CURRENT, 32'hABC);
        bus(1'b1, stk_pkg::OFS_CTRL_STATUS, 32'h7);
        gap(6);
        bus(1'b1, stk_pkg::OFS_CTRL_STATUS, 32'h6);
        rd(stk_pkg::OFS_CTRL_STATUS, 32'h0001_0006);
        rd(stk_pkg::OFS_CTRL_STATUS, 32'h6);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, stk_pkg::OFS_IRQ_MASK, 32'h1);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, stk_pkg::OFS_IRQ_STATUS, 32'h1);
        check({31'h0, irq}, 32'h0);
        rd(stk_pkg::OFS_IRQ_STATUS, 32'h0);
        bus(1'b1, stk_pkg::OFS_CTRL_STATUS, 32'h7);
        repeat (10) @(posedge clk);
        bus(1'b1, stk_pkg::OFS_CURRENT, 32'hFFFF_FFFF);
        bus(1'b1, stk_pkg::OFS_CTRL_STATUS, 32'h6);
        rd(stk_pkg::OFS_CTRL_STATUS, 32'h6);
        bus(1'b1, stk_pkg::OFS_CURRENT, 32'h1);
        rd(stk_pkg::OFS_CURRENT, 32'h0);
        quiet(20);
        bus(1'b1, stk_pkg::OFS_CTRL_STATUS, 32'h5);
        quiet(30);
        bus(1'b1, stk_pkg::OFS_CTRL_STATUS, 32'h4);
        rd(stk_pkg::OFS_CTRL_STATUS, 32'h0001_0004);
        bus(1'b1, stk_pkg::OFS_RELOAD, 32'h0);
        bus(1'b1, stk_pkg::OFS_CURRENT, 32'h0);
        bus(1'b1, stk_pkg::OFS_CTRL_STATUS, 32'h7);
        quiet(30);
        rd(stk_pkg::OFS_CURRENT, 32'h0);
        rd(stk_pkg::OFS_CTRL_STATUS, 32'h7);
        alt_run <= 1'b1;
        bus(1'b1, stk_pkg::OFS_CTRL_STATUS, 32'h3);
        bus(1'b1, stk_pkg::OFS_RELOAD, 32'h2);
        gap(12);
        alt_run <= 1'b0;
        quiet(30);
        stop_test();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule : test_stk_system_tick_timer
`default_nettype wire
